// [verilog/stop_seq_regs.svh]
// Register offsets, reset values and timing counts of the stop sequencer
`ifndef STOP_SEQ_REGS_SVH
`define STOP_SEQ_REGS_SVH
`define OFS_STOP_MODE_A 12'h000
`define OFS_STOP_MODE_B 12'h004
`define OFS_DECEL_TIME_1 12'h008
`define OFS_DECEL_TIME_2 12'h00C
`define OFS_INJ_LEVEL 12'h010
`define OFS_HOLD_DURATION 12'h014
`define OFS_HOLD_CURRENT 12'h018
`define OFS_RUN_FREQ 12'h01C
`define OFS_STATUS 12'h020
`define OFS_TP1_SEL 12'h024
`define OFS_TP2_SEL 12'h028
`define OFS_TP1_VALUE 12'h02C
`define OFS_TP2_VALUE 12'h030
`define MODE_COAST 3'h1
`define MODE_DC_BRAKE 3'h3
`define MODE_RAMP_STOP 3'h4
`define MODE_RAMP_HOLD 3'h5
`define RST_STOP_MODE 3'h1
`define RST_DECEL_TIME 16'h0064
`define RST_TP_SEL 16'h01F3
`define TP_SEL_MAX 16'h03E7
`define TP_RESERVED_LO 16'h0008
`define TP_RESERVED_HI 16'h0063
`define TP_OWN_FREQ 16'h0064
`define TP_OWN_STATE 16'h0065
`define TP_OWN_HOLD 16'h0066
`define FULL_SCALE_FREQ 16'h7FFF
`define CLK_PERIOD_NS 100
`define TICK_TIME_NS 1000000
`define TICK_CYCLES ((`TICK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [verilog/stop_seq_pkg.sv]
// Types shared by the stop sequencer modules
package stop_seq_pkg;
  typedef enum logic [2:0] {
    st_stopped,
    st_running,
    st_ramp,
    st_timed_hold,
    st_dc_inject
  } stop_state_e;
  typedef logic [15:0] word_t;
endpackage

// [verilog/decel_ramp.sv]
// Linear deceleration ramp from the present frequency down to zero
`timescale 1ns/1ps
module decel_ramp
  import stop_seq_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_freq,
  input wire logic active,
  input wire logic ms_tick,
  input wire logic [15:0] decel_ms,
  input wire logic [W-1:0] full_scale,
  // Result
  output logic [W-1:0] freq,
  output logic at_zero
);
  typedef struct packed {
    logic [W-1:0] freq;
    logic [31:0] acc;
  } ramp_s;
  ramp_s q, d;

  // Full scale falls to zero in decel_ms (a zero time clears at once); else at most one step a cycle, so very
  // short times stretch. A tick and a step share a cycle so no tick is lost.
  always_comb begin
    d = q;
    if (load) begin
      d.freq = load_freq;
      d.acc = 32'h0000_0000;
    end else if (active && q.freq != '0) begin
      if (decel_ms == 16'h0000) begin
        d.freq = '0;
      end else begin
        if (q.acc >= {16'h0000, decel_ms}) begin
          d.acc = q.acc - {16'h0000, decel_ms};
          d.freq = q.freq - W'(1);
        end
        if (ms_tick) begin
          d.acc = d.acc + 32'(full_scale);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign freq = q.freq;
  assign at_zero = (q.freq == '0);
endmodule

// [verilog/testpoint_mux.sv]
// Test-point selector decode onto a registered 16-bit value
`timescale 1ns/1ps
`include "stop_seq_regs.svh"
module testpoint_mux
  import stop_seq_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Selection and sources
  input wire logic [15:0] sel,
  input wire logic [127:0] drive_quantities,
  input wire logic [15:0] own_freq,
  input wire logic [15:0] own_state,
  input wire logic [15:0] own_hold,
  // Result
  output logic [15:0] value
);
  typedef struct packed {
    logic [15:0] value;
  } tp_s;
  tp_s q, d;

  function automatic logic [15:0] pick(input logic [15:0] code);
    logic [15:0] r;
    r = 16'h0000;
    if (code < `TP_RESERVED_LO) begin
      r = drive_quantities[code[2:0]*16 +: 16];
    end else if (code <= `TP_RESERVED_HI) begin
      r = 16'h0000;
    end else if (code == `TP_OWN_FREQ) begin
      r = own_freq;
    end else if (code == `TP_OWN_STATE) begin
      r = own_state;
    end else if (code == `TP_OWN_HOLD) begin
      r = own_hold;
    end
    return r;
  endfunction

  always_comb begin
    d = q;
    d.value = pick(sel);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign value = q.value;
endmodule

// [verilog/stop_sequencer.sv]
// Stop-mode sequencer for the output stage with APB registers and test points
//
// Behaviour
// - Coast: gates off at once, motor freewheels
// - Stop mode value 3 selects DC brake
// - DC brake: output stops, DC level applied
// - DC brake ends only on enable open/start
// - Ramp to zero, then gates off
// - Machine stop selects second deceleration time
// - Timed DC hold when time and level nonzero
// - Output voltage zero after hold time
// - Ramp to hold: ramp, then DC hold
// - Hold removed only by enable/start
// - Selectors take 0..999, reset 499
// - Selectors reach otherwise hidden internal quantities
// - Test-point values read-only, 0..65535
// - Codes 0..7 map fixed drive quantities
// - Codes 8..99 reserved, read zero
`timescale 1ns/1ps
`include "stop_seq_regs.svh"
module stop_sequencer
  import stop_seq_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter logic [15:0] FULL_SCALE = `FULL_SCALE_FREQ
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive commands
  input wire logic enable_in,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  input wire logic stop_select_b,
  input wire logic machine_stop,
  // Drive quantities for test points 0..7, code n in bits 16n+15:16n
  input wire logic [127:0] drive_quantities,
  // Power stage
  output logic gates_on,
  output logic [15:0] out_freq,
  output logic [15:0] out_volt,
  output logic dc_inject_on,
  output logic [15:0] dc_level
);
  typedef struct packed {
    stop_state_e state;
    logic [2:0] mode_a;
    logic [2:0] mode_b;
    logic [2:0] active_mode;
    logic [15:0] decel_1;
    logic [15:0] decel_2;
    logic [15:0] inj_level;
    logic [15:0] hold_ms;
    logic [15:0] hold_cur;
    logic [15:0] run_freq;
    logic [15:0] tp1_sel;
    logic [15:0] tp2_sel;
    logic [15:0] hold_cnt;
    logic [31:0] div_cnt;
    logic ms_tick;
    logic gates_on;
    logic dc_on;
    logic [15:0] dc_level;
    logic [15:0] volt;
    logic [15:0] freq;
    logic [31:0] prdata;
  } top_s;
  top_s q, d;

  logic [15:0] ramp_freq;
  logic ramp_zero;
  logic ramp_load;
  logic ramp_active;
  logic [15:0] tp1_value;
  logic [15:0] tp2_value;
  logic wr_en;
  logic rd_setup;
  logic hit;
  logic [2:0] sel_mode;

  function automatic logic mapped(input logic [11:0] a);
    logic r;
    r = 1'b0;
    unique case (a)
      `OFS_STOP_MODE_A, `OFS_STOP_MODE_B, `OFS_DECEL_TIME_1, `OFS_DECEL_TIME_2,
      `OFS_INJ_LEVEL, `OFS_HOLD_DURATION, `OFS_HOLD_CURRENT, `OFS_RUN_FREQ,
      `OFS_STATUS, `OFS_TP1_SEL, `OFS_TP2_SEL, `OFS_TP1_VALUE,
      `OFS_TP2_VALUE: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Stop codes other than the three named ones coast
  typedef enum logic [1:0] {
    beh_coast,
    beh_brake,
    beh_ramp_stop,
    beh_ramp_hold
  } stop_beh_e;

  function automatic stop_beh_e behaviour(input logic [2:0] code);
    stop_beh_e r;
    unique case (code)
      `MODE_DC_BRAKE: r = beh_brake;
      `MODE_RAMP_STOP: r = beh_ramp_stop;
      `MODE_RAMP_HOLD: r = beh_ramp_hold;
      default: r = beh_coast;
    endcase
    return r;
  endfunction

  // Out-of-range selector codes are dropped so each selector stays legal
  function automatic logic sel_legal(input logic [31:0] v);
    return v <= 32'(`TP_SEL_MAX);
  endfunction

  assign hit = mapped(paddr);
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Mode B only while its selection input is asserted
  assign sel_mode = stop_select_b ? q.mode_b : q.mode_a;

  // Ramp reloads from the running reference until the stop begins
  assign ramp_load = (q.state == st_running) || (q.state == st_stopped);
  assign ramp_active = (q.state == st_ramp);

  always_comb begin
    d = q;
    d.ms_tick = 1'b0;
    if (q.div_cnt >= 32'(TICK_CYCLES - 1)) begin
      d.div_cnt = 32'h0000_0000;
      d.ms_tick = 1'b1;
    end else begin
      d.div_cnt = q.div_cnt + 32'h0000_0001;
    end

    // Register writes
    if (wr_en) begin
      unique case (paddr)
        `OFS_STOP_MODE_A: d.mode_a = pwdata[2:0];
        `OFS_STOP_MODE_B: d.mode_b = pwdata[2:0];
        `OFS_DECEL_TIME_1: d.decel_1 = pwdata[15:0];
        `OFS_DECEL_TIME_2: d.decel_2 = pwdata[15:0];
        `OFS_INJ_LEVEL: d.inj_level = pwdata[15:0];
        `OFS_HOLD_DURATION: d.hold_ms = pwdata[15:0];
        `OFS_HOLD_CURRENT: d.hold_cur = pwdata[15:0];
        `OFS_RUN_FREQ: d.run_freq = pwdata[15:0];
        `OFS_TP1_SEL: begin
          if (sel_legal(pwdata)) begin
            d.tp1_sel = pwdata[15:0];
          end
        end
        `OFS_TP2_SEL: begin
          if (sel_legal(pwdata)) begin
            d.tp2_sel = pwdata[15:0];
          end
        end
        default: d.mode_a = q.mode_a;
      endcase
    end

    // Read data captured in the setup phase
    d.prdata = 32'h0000_0000;
    if (rd_setup) begin
      unique case (paddr)
        `OFS_STOP_MODE_A: d.prdata = {29'h0, q.mode_a};
        `OFS_STOP_MODE_B: d.prdata = {29'h0, q.mode_b};
        `OFS_DECEL_TIME_1: d.prdata = {16'h0, q.decel_1};
        `OFS_DECEL_TIME_2: d.prdata = {16'h0, q.decel_2};
        `OFS_INJ_LEVEL: d.prdata = {16'h0, q.inj_level};
        `OFS_HOLD_DURATION: d.prdata = {16'h0, q.hold_ms};
        `OFS_HOLD_CURRENT: d.prdata = {16'h0, q.hold_cur};
        `OFS_RUN_FREQ: d.prdata = {16'h0, q.run_freq};
        `OFS_STATUS: d.prdata = {ramp_freq, 10'h0, q.dc_on, q.gates_on, q.state, ramp_zero};
        `OFS_TP1_SEL: d.prdata = {16'h0, q.tp1_sel};
        `OFS_TP2_SEL: d.prdata = {16'h0, q.tp2_sel};
        `OFS_TP1_VALUE: d.prdata = {16'h0, tp1_value};
        `OFS_TP2_VALUE: d.prdata = {16'h0, tp2_value};
        default: d.prdata = 32'h0000_0000;
      endcase
    end

    // Stop sequencing
    unique case (q.state)
      st_stopped: begin
        d.gates_on = 1'b0;
        d.dc_on = 1'b0;
        d.volt = 16'h0000;
        if (start_cmd && enable_in) begin
          d.state = st_running;
        end
      end
      st_running: begin
        d.gates_on = 1'b1;
        d.volt = q.run_freq;
        if (stop_cmd) begin
          d.active_mode = sel_mode;
          unique case (behaviour(sel_mode))
            beh_brake: begin
              // Normal output ends now, DC on one phase instead
              d.state = st_dc_inject;
              d.dc_level = q.inj_level;
              d.dc_on = 1'b1;
              d.volt = 16'h0000;
            end
            beh_ramp_stop, beh_ramp_hold: begin
              d.state = st_ramp;
            end
            beh_coast: begin
              // Dynamic braking detail lives elsewhere, so it coasts here
              d.state = st_stopped;
              d.gates_on = 1'b0;
              d.volt = 16'h0000;
            end
          endcase
        end
      end
      st_ramp: begin
        d.volt = ramp_freq;
        if (ramp_zero) begin
          if (behaviour(q.active_mode) == beh_ramp_hold) begin
            d.state = st_dc_inject;
            d.dc_level = q.inj_level;
            d.dc_on = 1'b1;
            d.volt = 16'h0000;
          end else if (q.hold_ms != 16'h0000 && q.hold_cur != 16'h0000) begin
            d.state = st_timed_hold;
            d.dc_level = q.hold_cur;
            d.dc_on = 1'b1;
            d.hold_cnt = q.hold_ms;
            d.volt = 16'h0000;
          end else begin
            // Transistors turn off only once the output has reached zero
            d.state = st_stopped;
            d.gates_on = 1'b0;
            d.volt = 16'h0000;
          end
        end
      end
      st_timed_hold: begin
        if (q.ms_tick) begin
          d.hold_cnt = q.hold_cnt - 16'h0001;
          if (q.hold_cnt == 16'h0001) begin
            d.state = st_stopped;
            d.dc_on = 1'b0;
            d.dc_level = 16'h0000;
            d.gates_on = 1'b0;
            d.volt = 16'h0000;
          end
        end
      end
      st_dc_inject: begin
        // Holds until enable opens or start returns; a stop has no effect
        if (start_cmd && enable_in) begin
          d.state = st_running;
          d.dc_on = 1'b0;
          d.dc_level = 16'h0000;
        end
      end
    endcase

    // Opening the enable input releases the motor from any state
    if (!enable_in) begin
      d.state = st_stopped;
      d.dc_on = 1'b0;
      d.dc_level = 16'h0000;
      d.gates_on = 1'b0;
      d.volt = 16'h0000;
    end

    // Frequency is shown only while the stage drives or ramps
    d.freq = (d.state == st_running || d.state == st_ramp) ? d.volt : 16'h0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.state <= st_stopped;
      q.mode_a <= `RST_STOP_MODE;
      q.mode_b <= `RST_STOP_MODE;
      q.active_mode <= `RST_STOP_MODE;
      q.decel_1 <= `RST_DECEL_TIME;
      q.decel_2 <= `RST_DECEL_TIME;
      q.tp1_sel <= `RST_TP_SEL;
      q.tp2_sel <= `RST_TP_SEL;
    end else begin
      q <= d;
    end
  end

  decel_ramp #(
    .W(16)
  ) decel_ramp_inst (
    .pclk(pclk),
    .presetn(presetn),
    .load(ramp_load),
    .load_freq(q.run_freq),
    .active(ramp_active),
    .ms_tick(q.ms_tick),
    .decel_ms(machine_stop ? q.decel_2 : q.decel_1),
    .full_scale(FULL_SCALE),
    .freq(ramp_freq),
    .at_zero(ramp_zero)
  );

  // One decode per selector; index 0 feeds test point one
  logic [15:0] tp_sel [2];
  logic [15:0] tp_value [2];
  assign tp_sel[0] = q.tp1_sel;
  assign tp_sel[1] = q.tp2_sel;
  assign tp1_value = tp_value[0];
  assign tp2_value = tp_value[1];

  for (genvar i = 0; i < 2; i++) begin : g_tp
    testpoint_mux testpoint_mux_inst (
      .pclk(pclk),
      .presetn(presetn),
      .sel(tp_sel[i]),
      .drive_quantities(drive_quantities),
      .own_freq(out_freq),
      .own_state({13'h0, q.state}),
      .own_hold(q.hold_cnt),
      .value(tp_value[i])
    );
  end

  assign prdata = q.prdata;
  assign gates_on = q.gates_on;
  assign out_volt = q.volt;
  assign out_freq = q.freq;
  assign dc_inject_on = q.dc_on;
  assign dc_level = q.dc_level;
endmodule

// [test/stop_seq_monitor.sv]
// Port checker for the stop sequencer, bound to its top module
`timescale 1ns/1ps
module stop_seq_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus and commands
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic enable_in,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  // Power stage
  input wire logic gates_on,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] out_volt,
  input wire logic dc_inject_on,
  input wire logic [15:0] dc_level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_enable_drops_all: assert property (!enable_in |=> !gates_on && !dc_inject_on)
    else $error("stage still active after enable low");
  a_level_when_off: assert property (!dc_inject_on |-> dc_level == 16'h0000)
    else $error("dc level present without injection");
  a_inject_no_volt: assert property (dc_inject_on |-> out_volt == 16'h0000 && out_freq == 16'h0000)
    else $error("output voltage during injection");
  a_gates_off_idle: assert property (!gates_on |-> out_volt == 16'h0000 && out_freq == 16'h0000)
    else $error("output nonzero with gates off");
  a_volt_tracks_freq: assert property (gates_on && !dc_inject_on |-> out_freq == out_volt)
    else $error("voltage and frequency differ while driven");
  // Gates follow one cycle after the running state is entered
  logic start_idle;
  assign start_idle = enable_in && start_cmd && !gates_on && !dc_inject_on;
  a_start_runs: assert property (start_idle ##1 enable_in && !stop_cmd |=> gates_on)
    else $error("start from stopped not taken");
  a_idle_rdata: assert property (!psel |-> prdata == 32'h00000000)
    else $error("read data outside a transfer");
  a_err_access_only: assert property (!(psel && penable) |-> !pslverr)
    else $error("error response outside access phase");
  c_inject: cover property ($rose(dc_inject_on));
  c_gates_fall: cover property ($fell(gates_on));
  c_bus_err: cover property (pslverr);
endmodule

bind stop_sequencer stop_seq_monitor stop_seq_monitor_inst (.pclk, .presetn, .psel, .penable,
  .prdata, .pslverr, .enable_in, .start_cmd, .stop_cmd, .gates_on, .out_freq, .out_volt,
  .dc_inject_on,
  .dc_level);

// [test/power_stage_model.sv]
// Behavioural motor power stage: shaft speed and drive quantities
`timescale 1ns/1ps
module power_stage_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stage commands
  input wire logic gates_on,
  input wire logic [15:0] out_freq,
  input wire logic dc_inject_on,
  // Feedback
  output logic [127:0] drive_quantities,
  output logic [15:0] shaft_speed
);
  // Fixed readings keep test-point values predictable; low bits hold the code
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      drive_quantities[16*c +: 16] = 16'hA000 | 16'(c);
    end
  end
  // DC brakes the shaft hard, a coasting shaft only slows by friction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shaft_speed <= 16'h0000;
    end else if (gates_on && !dc_inject_on) begin
      shaft_speed <= out_freq;
    end else if (dc_inject_on) begin
      shaft_speed <= shaft_speed >> 1;
    end else if (shaft_speed != 16'h0000) begin
      shaft_speed <= shaft_speed - 16'h0001;
    end
  end
endmodule

// [test/stop_sequencer_tb.sv]
// Self-checking bench for the stop sequencer
`timescale 1ns/1ps
`include "stop_seq_regs.svh"
module stop_sequencer_tb;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic enable_in = 1'h0, start_cmd = 1'h0, stop_cmd = 1'h0;
  logic stop_select_b = 1'h0, machine_stop = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err_seen, gates_on, dc_inject_on;
  logic [15:0] out_freq, out_volt, dc_level, shaft_speed;
  logic [127:0] drive_quantities;
  int err_total = 0, cmp_count = 0, n;
  always #50 pclk = ~pclk;
  // Short millisecond tick keeps ramps and holds within a brief run
  stop_sequencer #(.TICK_CYCLES(10)) stop_sequencer_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .enable_in, .start_cmd, .stop_cmd,
    .stop_select_b, .machine_stop, .drive_quantities, .gates_on, .out_freq, .out_volt,
    .dc_inject_on, .dc_level);
  power_stage_model power_stage_model_inst (.pclk, .presetn, .gates_on, .out_freq,
    .dc_inject_on, .drive_quantities, .shaft_speed);
  task automatic end_sim;
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cb(input string nm, input logic exp, input logic got);
    chk(nm, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'h1 && k < 20);
    if (k >= 20) begin err_total++; end_sim; end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'h1, d);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    bus(a, 1'h0, 32'h0);
    chk(nm, exp, rd);
  endtask
  // One-cycle command pulse; returns where the answering cycle is sampled
  task automatic cmd(input bit stp);
    if (stp) stop_cmd <= 1'h1;
    else start_cmd <= 1'h1;
    @(posedge pclk);
    stop_cmd <= 1'h0;
    start_cmd <= 1'h0;
    @(posedge pclk);
  endtask
  // 0: output at zero, 1: injection on, 2: injection off, 3: output at reference
  task automatic wait_for(input int sel, input int lim, output int k);
    k = 0;
    while (k < lim && (sel == 0 ? out_volt !== 16'h0000 : sel == 3 ? out_volt !== 16'h0100 :
        dc_inject_on !== sel[0])) begin
      @(posedge pclk);
      k++;
    end
    if (k >= lim) begin err_total++; end_sim; end
  endtask
  task automatic go(input logic [2:0] mode);
    int k;
    wr(`OFS_STOP_MODE_A, {29'h0, mode});
    cmd(1'b0);
    wait_for(3, 3000, k);
    cb("gates_on run", 1'h1, gates_on);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    enable_in <= 1'h1;
    @(posedge pclk);
    rdc("sel1 reset", `OFS_TP1_SEL, 32'h1F3);
    rdc("sel2 reset", `OFS_TP2_SEL, 32'h1F3);
    rdc("mode reset", `OFS_STOP_MODE_A, 32'h1);
    for (int c = 0; c < 8; c++) begin
      wr(`OFS_TP1_SEL, c);
      rdc("tp1 value", `OFS_TP1_VALUE, {16'h0, 16'hA000 | 16'(c)});
    end
    wr(`OFS_TP2_SEL, 32'h32);
    rdc("tp2 reserved", `OFS_TP2_VALUE, 32'h0);
    wr(`OFS_TP2_VALUE, 32'h1234);
    rdc("tp2 read only", `OFS_TP2_VALUE, 32'h0);
    wr(`OFS_TP2_SEL, 32'h3E8);
    rdc("sel over max", `OFS_TP2_SEL, 32'h32);
    wr(`OFS_TP2_SEL, 32'h3E7);
    rdc("sel max", `OFS_TP2_SEL, 32'h3E7);
    wr(`OFS_TP2_SEL, 32'h2);
    rdc("tp2 code 2", `OFS_TP2_VALUE, 32'hA002);
    rdc("unmapped", 12'hFFC, 32'h0);
    cb("pslverr", 1'h1, err_seen);
    wr(`OFS_RUN_FREQ, 32'h100);
    wr(`OFS_INJ_LEVEL, 32'h55);
    wr(`OFS_DECEL_TIME_1, 32'h7FFF);
    wr(`OFS_DECEL_TIME_2, 32'h800);
    wr(`OFS_HOLD_DURATION, 32'h2);
    wr(`OFS_HOLD_CURRENT, 32'h33);
    go(`MODE_COAST);
    cmd(1'b1);
    cb("coast gates", 1'h0, gates_on);
    chk("coast volt", 32'h0, {16'h0, out_volt});
    cb("coast spin", 1'h1, shaft_speed != 16'h0000);
    wr(`OFS_STOP_MODE_B, {29'h0, `MODE_DC_BRAKE});
    stop_select_b <= 1'h1;
    go(`MODE_COAST);
    cmd(1'b1);
    cb("brake on", 1'h1, dc_inject_on);
    chk("brake level", 32'h55, {16'h0, dc_level});
    repeat (40) @(posedge pclk);
    cb("brake held", 1'h1, dc_inject_on);
    cmd(1'b0);
    cb("brake start", 1'h0, dc_inject_on);
    cb("restart gates", 1'h1, gates_on);
    cmd(1'b1);
    enable_in <= 1'h0;
    repeat (2) @(posedge pclk);
    cb("brake enable", 1'h0, dc_inject_on);
    enable_in <= 1'h1;
    stop_select_b <= 1'h0;
    machine_stop <= 1'h1;
    go(`MODE_RAMP_STOP);
    cmd(1'b1);
    wait_for(0, 400, n);
    wait_for(1, 5, n);
    chk("hold level", 32'h33, {16'h0, dc_level});
    wait_for(2, 40, n);
    cb("hold length", 1'h1, n >= 10);
    cb("hold end gates", 1'h0, gates_on);
    wr(`OFS_HOLD_CURRENT, 32'h0);
    go(`MODE_RAMP_STOP);
    cmd(1'b1);
    wait_for(0, 400, n);
    repeat (2) @(posedge pclk);
    cb("no hold dc", 1'h0, dc_inject_on);
    cb("no hold gates", 1'h0, gates_on);
    machine_stop <= 1'h0;
    go(`MODE_RAMP_HOLD);
    cmd(1'b1);
    wait_for(1, 3000, n);
    cb("slow decel", 1'h1, n > 400);
    chk("hold inj level", 32'h55, {16'h0, dc_level});
    repeat (40) @(posedge pclk);
    cb("hold kept", 1'h1, dc_inject_on);
    wr(`OFS_TP1_SEL, 32'h65);
    rdc("tp own state", `OFS_TP1_VALUE, 32'h4);
    cmd(1'b0);
    cb("hold start", 1'h0, dc_inject_on);
    cb("hold restart", 1'h1, gates_on);
    end_sim;
  end
endmodule
